// [common/dsc_pkg.sv]
/*
  dsc_pkg: register map, descriptor field layout, reset values and
  engine states of the descriptor status/control engine.
  Assumes a 32-bit APB with 12 address bits.
*/
package dsc_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_BUFSZ  = 12'h004;
  localparam logic [11:0] OFF_TBLLEN = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_DESC   = 12'h100;
  // control and status fields
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_RX     = 1;
  localparam int STS_ACTIVE  = 0;
  localparam int STS_EOB     = 1;
  localparam int STS_DERR    = 2;
  localparam int STS_IDX_LO  = 16;
  // descriptor word: bit n of the field sits at word bit 31-n
  localparam int SC_READY = 31;
  localparam int SC_WRAP  = 30;
  localparam int SC_CONT  = 29;
  localparam int SC_LAST  = 28;
  localparam int SC_FIRST = 27;
  localparam int SC_INT   = 26;
  localparam int SC_CC_HI = 25;
  localparam int SC_CC_LO = 16;
  localparam int SC_HI    = 31;
  localparam int SC_LO    = 16;
  localparam int LEN_HI   = 15;
  localparam int LEN_LO   = 0;
  // reset values
  localparam logic [15:0] BUFSZ_RST  = 16'h0100;
  localparam logic [8:0]  TBLLEN_RST = 9'h010;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_LOAD, ST_XFER, ST_WBACK, ST_NOTIFY
  } dsc_state_t;
endpackage : dsc_pkg

// [verif/dsc_cc_model.sv]
/*
  dsc_cc_model: behavioural channel controller on the far side of the
  descriptor engine. Assumes pclk and that the bench calls run() only
  once the engine has gone idle again.
*/
`timescale 1ns/100ps
module dsc_cc_model (
  input  wire logic        pclk,
  output logic             cc_req,
  output logic             cc_buf_done,
  output logic             cc_pkt_end,
  output logic             cc_err,
  output logic             cc_backup,
  output logic      [15:0] cc_byte_cnt,
  output logic      [9:0]  cc_status,
  input  wire logic        cc_ctrl_valid,
  input  wire logic [15:0] cc_ctrl_word
);
  initial begin
    {cc_req, cc_buf_done, cc_pkt_end, cc_err, cc_backup} = 5'h00;
    cc_byte_cnt = 16'h0000;
    cc_status   = 10'h000;
  end
  //////////////////////////////////////////////////////////////////////
  // f = {packet end, error, backup}; status only touches its own field
  task run(input logic [2:0] f, input int dly, input logic [15:0] cnt,
           input logic [9:0] st, output logic [15:0] w, output logic got);
    int n;
    got = 1'b0;
    w   = 16'h0000;
    n   = 0;
    @(posedge pclk) cc_req <= 1'b1;
    while (!got && n < 8) begin
      @(posedge pclk);
      n++;
      if (cc_ctrl_valid === 1'b1) begin
        got = 1'b1;
        w   = cc_ctrl_word;
      end
    end
    cc_req <= 1'b0;
    if (got) begin
      repeat (dly) @(posedge pclk);
      cc_buf_done <= ~f[1];
      cc_err      <= f[1];
      cc_pkt_end  <= f[2];
      cc_backup   <= f[0];
      cc_byte_cnt <= cnt;
      cc_status   <= st;
      @(posedge pclk);
      {cc_buf_done, cc_err, cc_pkt_end, cc_backup} <= 4'h0;
      cc_byte_cnt <= ~cnt;
      cc_status   <= ~st;
      repeat (5) @(posedge pclk);
    end
  endtask : run
endmodule : dsc_cc_model

// [verif/dsc_ctrl_tb.sv]
/*
  dsc_ctrl_tb: self-checking bench for dsc_ctrl over APB with the
  channel controller model. Assumes the register map of dsc_pkg.
*/
`timescale 1ns/100ps
module dsc_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, cc_req, cc_buf_done, cc_pkt_end, cc_err, cc_backup;
  logic [15:0] cc_byte_cnt, cc_ctrl_word;
  logic [9:0]  cc_status;
  logic        cc_ctrl_valid, cc_status_rd, eob_irq;
  int          n_fail, check_count, n_eob, n_srd;
  logic [31:0] q;
  logic        e;

  dsc_ctrl #(.IDX_W(6)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cc_req(cc_req), .cc_buf_done(cc_buf_done),
    .cc_pkt_end(cc_pkt_end), .cc_err(cc_err), .cc_backup(cc_backup),
    .cc_byte_cnt(cc_byte_cnt), .cc_status(cc_status), .cc_ctrl_valid(cc_ctrl_valid),
    .cc_ctrl_word(cc_ctrl_word), .cc_status_rd(cc_status_rd), .eob_irq(eob_irq));
  dsc_cc_model i_cc (.pclk(pclk), .cc_req(cc_req), .cc_buf_done(cc_buf_done),
    .cc_pkt_end(cc_pkt_end), .cc_err(cc_err), .cc_backup(cc_backup),
    .cc_byte_cnt(cc_byte_cnt), .cc_status(cc_status), .cc_ctrl_valid(cc_ctrl_valid),
    .cc_ctrl_word(cc_ctrl_word));

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (eob_irq === 1'b1) n_eob++;
    if (cc_status_rd === 1'b1) n_srd++;
  end
  //////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  task chk_word(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_word
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk_word(nm, x, q & m);
    chk_word({nm, " slverr"}, 32'h0, {31'h0, e});
  endtask : rd
  task run_chk(input logic [5:0] i, input logic [31:0] d, input logic [2:0] f, input int dly,
               input logic [15:0] cnt, input logic [9:0] st, input logic [31:0] x);
    logic [15:0] w;
    logic        g;
    apb(1'b1, dsc_pkg::OFF_DESC + 12'({i, 2'b00}), d);
    i_cc.run(f, dly, cnt, st, w, g);
    chk_word("ctrl word", {15'h0, d[31], d[31] ? d[31:16] : 16'h0}, {15'h0, g, w});
    rd(dsc_pkg::OFF_DESC + 12'({i, 2'b00}), 32'hFFFF_FFFF, x, "descriptor");
  endtask : run_chk
  //////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    paddr = 12'h000; pwdata = 32'h0;
    {n_fail, check_count, n_eob, n_srd} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(dsc_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl reset");
    rd(dsc_pkg::OFF_BUFSZ, 32'hFFFF_FFFF, 32'h0000_0100, "bufsz reset");
    rd(dsc_pkg::OFF_TBLLEN, 32'hFFFF_FFFF, 32'h0000_0010, "tbllen reset");
    rd(dsc_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0, "status reset");
    apb(1'b0, 12'h010, 32'h0);
    chk_word("unmapped slverr", 32'h1, {31'h0, e});
    apb(1'b0, 12'h102, 32'h0);
    chk_word("unaligned slverr", 32'h1, {31'h0, e});
    $display("test regs done");
    apb(1'b1, dsc_pkg::OFF_TBLLEN, 32'h4);
    apb(1'b1, dsc_pkg::OFF_CTRL, 32'h1);
    // transmit: software keeps reserved bit 4 zero, last only at packet end
    run_chk(6'd0, 32'h8555_0040, 3'b000, 0, 16'h1234, 10'h2AA, 32'h0555_0040);
    chk_word("eob pulses", 32'd1, n_eob);
    rd(dsc_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0001_0003, "eob sticky");
    apb(1'b1, dsc_pkg::OFF_STATUS, 32'h2);
    rd(dsc_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0001_0001, "eob cleared");
    run_chk(6'd1, 32'hB000_0010, 3'b100, 3, 16'h0000, 10'h3C3, 32'hB3C3_0010);
    run_chk(6'd2, 32'hD000_0008, 3'b101, 1, 16'h0000, 10'h001, 32'hD001_0008);
    rd(dsc_pkg::OFF_STATUS, 32'hFFFF_0003, 32'h0000_0001, "tx wrap index");
    run_chk(6'd0, 32'h0555_0040, 3'b000, 0, 16'h0000, 10'h000, 32'h0555_0040);
    rd(dsc_pkg::OFF_STATUS, 32'hFFFF_0007, 32'h0000_0004, "not ready refused");
    chk_word("status reads tx", 32'd2, n_srd);
    $display("test tx done");
    // receive: software leaves empty descriptors alone until returned
    apb(1'b1, dsc_pkg::OFF_STATUS, 32'h4);
    apb(1'b1, dsc_pkg::OFF_BUFSZ, 32'h0200);
    rd(dsc_pkg::OFF_BUFSZ, 32'hFFFF_FFFF, 32'h0000_0200, "bufsz rw");
    apb(1'b1, dsc_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, dsc_pkg::OFF_CTRL, 32'h3);
    run_chk(6'd0, 32'h84AA_0000, 3'b000, 2, 16'h1234, 10'h3FF, 32'h0CAA_0200);
    run_chk(6'd1, 32'hA000_0000, 3'b100, 0, 16'h0077, 10'h155, 32'hB155_0077);
    run_chk(6'd2, 32'hA000_0000, 3'b010, 1, 16'h0005, 10'h2AA, 32'h2AAA_0005);
    rd(dsc_pkg::OFF_STATUS, 32'hFFFF_0001, 32'h0, "error deactivates");
    chk_word("eob pulses rx", 32'd2, n_eob);
    chk_word("status reads", 32'd4, n_srd);
    $display("test rx done");
    give_verdict();
  end
endmodule : dsc_ctrl_tb

// [verilog/dsc_bd_mem.sv]
/*
  dsc_bd_mem: two-port descriptor table, registered read data.
  Assumes port a (engine) wins a same-address write collision.
*/
`timescale 1ns/100ps
module dsc_bd_mem #(
  parameter int IDX_W = 6
) (
  input  wire logic             clk,
  input  wire logic             a_en,
  input  wire logic             a_we,
  input  wire logic [IDX_W-1:0] a_addr,
  input  wire logic [31:0]      a_wdata,
  output logic      [31:0]      a_rdata,
  input  wire logic             b_en,
  input  wire logic             b_we,
  input  wire logic [IDX_W-1:0] b_addr,
  input  wire logic [31:0]      b_wdata,
  output logic      [31:0]      b_rdata
);
  logic [31:0] mem [0:(1<<IDX_W)-1];

  always_ff @(posedge clk) begin
    if (b_en && b_we && !(a_en && a_we && a_addr == b_addr)) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_en && a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (a_en) begin
      a_rdata <= mem[a_addr];
    end
    if (b_en) begin
      b_rdata <= mem[b_addr];
    end
  end
endmodule : dsc_bd_mem

// [verilog/dsc_ctrl.sv]
/*
  dsc_ctrl: descriptor status/control engine for one channel, with an
  APB register file and the descriptor table behind it.
  Assumes the channel controller runs on pclk and holds its status,
  byte count and flags valid with its done pulse.
*/
`timescale 1ns/100ps
module dsc_ctrl #(
  parameter int IDX_W = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cc_req,
  input  wire logic        cc_buf_done,
  input  wire logic        cc_pkt_end,
  input  wire logic        cc_err,
  input  wire logic        cc_backup,
  input  wire logic [15:0] cc_byte_cnt,
  input  wire logic [9:0]  cc_status,
  output logic             cc_ctrl_valid,
  output logic      [15:0] cc_ctrl_word,
  output logic             cc_status_rd,
  output logic             eob_irq
);
  if (IDX_W < 1 || IDX_W > 8) begin : g_bad_idx
    $error("IDX_W must lie in 1..8");
  end

  localparam logic [11:0] DESC_END = 12'(dsc_pkg::OFF_DESC + (4 << IDX_W));

  typedef struct packed {
    dsc_pkg::dsc_state_t st;
    logic [IDX_W-1:0]    idx;
    logic [31:0]         word;
    logic                active, rx;
    logic [15:0]         bufsz;
    logic [IDX_W:0]      tbllen;
    logic                first, eob_sts, derr_sts, done_end, done_err, done_bkp;
    logic [15:0]         done_cnt;
    logic [9:0]          done_sts;
    logic [1:0]          apb_ph;
    logic [31:0]         prdata;
    logic                pready, pslverr;
    logic                ctrl_valid;
    logic [15:0]         ctrl_word;
    logic                sts_rd, eob_irq;
  } dsc_ctrl_state_t;

  dsc_ctrl_state_t r_reg;
  dsc_ctrl_state_t r_next;

  logic             a_en, a_we, b_en, b_we;
  logic [31:0]      a_wdata, a_rdata, b_rdata;
  logic             is_desc, is_reg, keep_own;
  logic [31:0]      regval, wb;
  logic [IDX_W-1:0] idx_adv;
  logic [11:0]      desc_off;

  // table index counted from the table base, whatever IDX_W is
  dsc_bd_mem #(.IDX_W(IDX_W)) u_mem (
    .clk(pclk), .a_en(a_en), .a_we(a_we), .a_addr(r_reg.idx), .a_wdata(a_wdata),
    .a_rdata(a_rdata), .b_en(b_en), .b_we(b_we), .b_addr(desc_off[IDX_W+1:2]),
    .b_wdata(pwdata), .b_rdata(b_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // write-back word and next index
  always_comb begin
    wb = r_reg.word;
    keep_own = (!r_reg.rx && r_reg.done_bkp)
      || (r_reg.word[dsc_pkg::SC_CONT] && !r_reg.done_err);
    wb[dsc_pkg::SC_READY] = keep_own;
    if (r_reg.rx) begin
      wb[dsc_pkg::SC_LAST]  = r_reg.done_end;
      wb[dsc_pkg::SC_FIRST] = r_reg.first;
      wb[dsc_pkg::LEN_HI:dsc_pkg::LEN_LO] = (r_reg.done_end || r_reg.done_err)
        ? r_reg.done_cnt : r_reg.bufsz;
    end
    if (r_reg.done_end || r_reg.done_err) begin
      wb[dsc_pkg::SC_CC_HI:dsc_pkg::SC_CC_LO] = r_reg.done_sts;
    end
    if (r_reg.word[dsc_pkg::SC_WRAP]
        || {1'b0, r_reg.idx} == r_reg.tbllen - 1'b1) begin
      idx_adv = '0;
    end else begin
      idx_adv = r_reg.idx + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb decode
  always_comb begin
    is_desc = paddr >= dsc_pkg::OFF_DESC && paddr < DESC_END && paddr[1:0] == 2'b00;
    desc_off = paddr - dsc_pkg::OFF_DESC;
    is_reg  = 1'b1;
    regval  = '0;
    case (paddr)
      dsc_pkg::OFF_CTRL: begin
        regval[dsc_pkg::CTRL_ACTIVE] = r_reg.active;
        regval[dsc_pkg::CTRL_RX]     = r_reg.rx;
      end
      dsc_pkg::OFF_BUFSZ:  regval[15:0] = r_reg.bufsz;
      dsc_pkg::OFF_TBLLEN: regval[IDX_W:0] = r_reg.tbllen;
      dsc_pkg::OFF_STATUS: begin
        regval[dsc_pkg::STS_ACTIVE] = r_reg.active;
        regval[dsc_pkg::STS_EOB]    = r_reg.eob_sts;
        regval[dsc_pkg::STS_DERR]   = r_reg.derr_sts;
        regval[dsc_pkg::STS_IDX_LO +: IDX_W] = r_reg.idx;
      end
      default: is_reg = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_next = r_reg;
    r_next.ctrl_valid = 1'b0;
    r_next.sts_rd = 1'b0;
    r_next.eob_irq = 1'b0;
    a_en = 1'b0;
    a_we = 1'b0;
    a_wdata = wb;
    b_en = 1'b0;
    b_we = 1'b0;
    // apb slave
    case (r_reg.apb_ph)
      2'd0: begin
        if (psel && penable && !r_reg.pready) begin
          r_next.apb_ph = 2'd1;
          b_en = is_desc;
        end
      end
      2'd1: begin
        r_next.apb_ph  = 2'd2;
        r_next.pready  = 1'b1;
        r_next.pslverr = !(is_desc || is_reg);
        r_next.prdata  = pwrite ? 32'h0000_0000 : (is_desc ? b_rdata : regval);
      end
      default: begin
        r_next.apb_ph  = 2'd0;
        r_next.pready  = 1'b0;
        r_next.pslverr = 1'b0;
        if (pwrite && !r_reg.pslverr) begin
          b_en = is_desc;
          b_we = is_desc;
          case (paddr)
            dsc_pkg::OFF_CTRL: begin
              if (pwdata[dsc_pkg::CTRL_ACTIVE] && !r_reg.active) begin
                r_next.idx   = '0;
                r_next.first = 1'b1;
              end
              r_next.active = pwdata[dsc_pkg::CTRL_ACTIVE];
              r_next.rx     = pwdata[dsc_pkg::CTRL_RX];
            end
            dsc_pkg::OFF_BUFSZ:  r_next.bufsz = pwdata[15:0];
            dsc_pkg::OFF_TBLLEN: r_next.tbllen = pwdata[IDX_W:0];
            dsc_pkg::OFF_STATUS: begin
              if (pwdata[dsc_pkg::STS_EOB]) begin
                r_next.eob_sts = 1'b0;
              end
              if (pwdata[dsc_pkg::STS_DERR]) begin
                r_next.derr_sts = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
    endcase
    // descriptor engine; its sets come last so they beat clears
    case (r_reg.st)
      dsc_pkg::ST_IDLE: begin
        if (r_reg.active && cc_req) begin
          r_next.st = dsc_pkg::ST_FETCH;
        end
      end
      dsc_pkg::ST_FETCH: begin
        a_en = 1'b1;
        r_next.st = dsc_pkg::ST_LOAD;
      end
      dsc_pkg::ST_LOAD: begin
        r_next.word = a_rdata;
        if (!a_rdata[dsc_pkg::SC_READY]) begin
          r_next.active   = 1'b0;
          r_next.idx      = '0;
          r_next.first    = 1'b1;
          r_next.derr_sts = 1'b1;
          r_next.st       = dsc_pkg::ST_IDLE;
        end else begin
          r_next.ctrl_valid = 1'b1;
          r_next.ctrl_word  = a_rdata[dsc_pkg::SC_HI:dsc_pkg::SC_LO];
          r_next.st         = dsc_pkg::ST_XFER;
        end
      end
      dsc_pkg::ST_XFER: begin
        if (cc_buf_done || cc_err) begin
          r_next.done_end = cc_pkt_end && !cc_err;
          r_next.done_err = cc_err;
          r_next.done_bkp = cc_backup;
          r_next.done_cnt = cc_byte_cnt;
          r_next.done_sts = cc_status;
          r_next.sts_rd   = cc_pkt_end || cc_err;
          r_next.st       = dsc_pkg::ST_WBACK;
        end
      end
      dsc_pkg::ST_WBACK: begin
        a_en = 1'b1;
        a_we = 1'b1;
        r_next.first = r_reg.done_end || r_reg.done_err;
        if (r_reg.done_err) begin
          r_next.active = 1'b0;
          r_next.idx    = '0;
        end else begin
          r_next.idx = idx_adv;
        end
        r_next.st = dsc_pkg::ST_NOTIFY;
      end
      dsc_pkg::ST_NOTIFY: begin
        if (r_reg.word[dsc_pkg::SC_INT]) begin
          r_next.eob_sts = 1'b1;
          r_next.eob_irq = 1'b1;
        end
        r_next.st = dsc_pkg::ST_IDLE;
      end
      default: r_next.st = dsc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg        <= '0;
      r_reg.st     <= dsc_pkg::ST_IDLE;
      r_reg.bufsz  <= dsc_pkg::BUFSZ_RST;
      r_reg.tbllen <= (IDX_W+1)'(dsc_pkg::TBLLEN_RST);
      r_reg.first  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata        = r_reg.prdata;
  assign pready        = r_reg.pready;
  assign pslverr       = r_reg.pslverr;
  assign cc_ctrl_valid = r_reg.ctrl_valid;
  assign cc_ctrl_word  = r_reg.ctrl_word;
  assign cc_status_rd  = r_reg.sts_rd;
  assign eob_irq       = r_reg.eob_irq;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_tx, wr_rx;
  assign wr_tx = a_we && !r_reg.rx;
  assign wr_rx = a_we && r_reg.rx;

  sequence s_owned_load;
    r_reg.st == dsc_pkg::ST_LOAD && a_rdata[dsc_pkg::SC_READY];
  endsequence
  sequence s_ctrl_out;
    cc_ctrl_valid && cc_ctrl_word == $past(a_rdata[31:16]);
  endsequence
  property p_ctrl_sent;
    s_owned_load |=> s_ctrl_out;
  endproperty

  a_ctrl_word_sent: assert property (p_ctrl_sent)
    else $error("control word not forwarded");
  a_eob_after_write: assert property (eob_irq |-> $past(a_we, 2))
    else $error("end-of-buffer pulse before write-back");
  a_eob_on_int: assert property (
    r_reg.st == dsc_pkg::ST_NOTIFY && r_reg.word[dsc_pkg::SC_INT]
    |=> eob_irq && r_reg.eob_sts)
    else $error("interrupt bit ignored");
  a_cc_bits_kept: assert property (
    a_we && !r_reg.done_end && !r_reg.done_err
    |-> a_wdata[25:16] == r_reg.word[25:16])
    else $error("controller field altered");
  a_status_stored: assert property (
    a_we && r_reg.done_end |-> a_wdata[25:16] == r_reg.done_sts)
    else $error("controller status not stored");
  a_tx_len_kept: assert property (wr_tx |-> a_wdata[15:0] == r_reg.word[15:0])
    else $error("length changed on transmit");
  a_tx_ready_clr: assert property (
    wr_tx && !r_reg.done_bkp && (!r_reg.word[29] || r_reg.done_err) |-> !a_wdata[31])
    else $error("ready left set");
  a_tx_cont_keep: assert property (
    wr_tx && r_reg.word[dsc_pkg::SC_CONT] && !r_reg.done_err |-> a_wdata[dsc_pkg::SC_READY])
    else $error("ready cleared in continuous mode");
  a_rx_empty: assert property (
    wr_rx |-> a_wdata[31] == (r_reg.word[29] && !r_reg.done_err))
    else $error("empty bit wrong");
  a_rx_first_last: assert property (
    wr_rx |-> a_wdata[28] == r_reg.done_end && a_wdata[27] == r_reg.first)
    else $error("first or last bit wrong");
  a_rx_length: assert property (
    wr_rx && !r_reg.done_end && !r_reg.done_err |-> a_wdata[15:0] == r_reg.bufsz)
    else $error("full buffer length wrong");
  a_wrap_head: assert property (
    a_we && r_reg.word[30] && !r_reg.done_err |=> r_reg.idx == '0)
    else $error("wrap did not return to head");
  a_no_reuse: assert property (
    r_reg.st == dsc_pkg::ST_LOAD && !a_rdata[31] |=> !r_reg.active && !cc_ctrl_valid)
    else $error("non-owned descriptor used");
endmodule : dsc_ctrl
